// File: rtl/spd_regs.svh
// Register offsets, field positions, reset values and constants of the synth config block
`ifndef SPD_REGS_SVH
`define SPD_REGS_SVH

// ------------------------------------------------------------
// Full 8-bit register offsets
// ------------------------------------------------------------
`define SPD_OFF_A_ADVANCE 8'h78
`define SPD_OFF_B_ADVANCE 8'h79
`define SPD_OFF_BANK 8'h7F
`define SPD_OFF_DIV_LO 8'h80
`define SPD_OFF_DIV_MID 8'h81
`define SPD_OFF_DIV_HI 8'h82

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SPD_RST_ADVANCE 8'h00
`define SPD_RST_BANK 8'h00
`define SPD_RST_DIV 24'h00_0002

// ------------------------------------------------------------
// Divider register fields and the bank bit
// ------------------------------------------------------------
`define SPD_MODE_HI 23
`define SPD_MODE_LO 20
`define SPD_MODE_SPECIAL 4'hF
`define SPD_BIT_BOUNDARY 19
`define SPD_BIT_POLARITY 18
`define SPD_SRC_HI 17
`define SPD_SRC_LO 16
`define SPD_COUNT_HI 15
`define SPD_BANK_BIT 0

`endif

// File: rtl/spd_pkg.sv
// Types shared by the synth config block
package spd_pkg;

  // Reference clock of the frame pulse
  typedef enum logic [1:0] {
    SPD_SRC_LOWFREQ = 2'b00,
    SPD_SRC_POST_B = 2'b01,
    SPD_SRC_POST_C = 2'b10,
    SPD_SRC_POST_D = 2'b11
  } spd_src_e;

  // Frame pulse generator state
  typedef enum logic {
    SPD_FR_GAP,
    SPD_FR_PULSE
  } spd_frame_e;

endpackage

// File: rtl/spd_divider.sv
// Tick-driven clock divider with near 50% duty output
`timescale 1ns/1ps
`default_nettype none

module spd_divider
#(
  parameter int WIDTH = 24
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic [WIDTH-1:0] divisor,
  output logic clk_out
);

  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic next_out;
  logic [WIDTH-1:0] eff;

  // Ratios below two cannot give a split waveform, so they act as two
  function automatic logic [WIDTH-1:0] spd_eff_div(input logic [WIDTH-1:0] d);
    spd_eff_div = (d < WIDTH'(2)) ? WIDTH'(2) : d;
  endfunction

  // ------------------------------------------------------------
  // Next count and level
  // ------------------------------------------------------------
  always_comb
  begin
    eff = spd_eff_div(divisor);
    next_cnt = cnt;
    next_out = clk_out;
    if (tick)
    begin
      // A shrinking divisor must not leave the count stranded above it
      next_cnt = (cnt >= eff - WIDTH'(1)) ? '0 : cnt + WIDTH'(1);
      // High for the larger half when the ratio is odd
      next_out = (next_cnt < eff - (eff >> 1));
    end
  end

  // ------------------------------------------------------------
  // State registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      clk_out <= 1'b1;
    end
    else
    begin
      cnt <= next_cnt;
      clk_out <= next_out;
    end
  end

endmodule

`default_nettype wire

// File: rtl/spd_top.sv
// Phase advance, bank select and first output divider of synthesizer 0
`timescale 1ns/1ps
`default_nettype none
`include "spd_regs.svh"

// Functional notes
// - Synthesizer 0 clocks are advanced by an 8-bit unsigned count of period/256 steps.
// - Synthesizer 1 clocks are advanced by an 8-bit unsigned count of period/256 steps.
// - Bank bit 0 maps host accesses to the lower range (0) or the range from 0x80 (1).
// - The host sets the bank bit before touching the upper half of the map.
// - In special mode with a nonzero source, pulses are spaced by the low 16-bit count.
// - In special mode with source zero, a low-frequency clock of 2x base / count is made.
// - Outside special mode, the full 24-bit value divides the synthesizer 0 clock.
// - The source field picks low-frequency, B, C or D; a pulse lasts one source period.
// - In special mode bit 18 sets pulse polarity, otherwise it is a divisor bit.
// - Bits 23:20 equal to 1111 select special mode; other values give a near 50% clock (high for the larger half when odd).
// - In special mode bit 19 places the frame boundary mid-pulse (0) or at the edge (1).
module spd_top
  import spd_pkg::*;
#(
  parameter int DIV_WIDTH = 24,
  parameter int COUNT_WIDTH = 16
)
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [6:0] HOST_ADDR,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_WDATA,
  output logic [7:0] HOST_RDATA,
  input wire logic BASE_TICK,
  input wire logic POSTDIV_B_CLK,
  input wire logic POSTDIV_C_CLK,
  input wire logic POSTDIV_D_CLK,
  output logic [7:0] SYNTH_A_ADVANCE_STEPS,
  output logic [7:0] SYNTH_B_ADVANCE_STEPS,
  output logic FIRST_OUT,
  output logic FRAME_MARK
);

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Async assert, clean release two edges later
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0] synth_a_phase_advance;
  logic [7:0] synth_b_phase_advance;
  logic bank_sel;
  logic [DIV_WIDTH-1:0] synth_a_first_output_divider;
  logic [7:0] next_a_adv;
  logic [7:0] next_b_adv;
  logic next_bank;
  logic [DIV_WIDTH-1:0] next_div;
  logic [7:0] next_rdata;
  logic [7:0] full_addr;

  // The bank register sits at the top of both pages so it is never lost
  function automatic logic [7:0] spd_full_addr(input logic bank, input logic [6:0] a);
    spd_full_addr = ({1'b0, a} == `SPD_OFF_BANK) ? `SPD_OFF_BANK : {bank, a};
  endfunction

  // Register updates and read mux
  always_comb
  begin
    full_addr = spd_full_addr(bank_sel, HOST_ADDR);
    next_a_adv = synth_a_phase_advance;
    next_b_adv = synth_b_phase_advance;
    next_bank = bank_sel;
    next_div = synth_a_first_output_divider;
    next_rdata = HOST_RDATA;
    if (HOST_WR)
    begin
      case (full_addr)
        `SPD_OFF_A_ADVANCE: next_a_adv = HOST_WDATA;
        `SPD_OFF_B_ADVANCE: next_b_adv = HOST_WDATA;
        `SPD_OFF_BANK: next_bank = HOST_WDATA[`SPD_BANK_BIT];
        `SPD_OFF_DIV_LO: next_div[7:0] = HOST_WDATA;
        `SPD_OFF_DIV_MID: next_div[15:8] = HOST_WDATA;
        `SPD_OFF_DIV_HI: next_div[23:16] = HOST_WDATA;
        default: next_div = synth_a_first_output_divider;
      endcase
    end
    if (HOST_RD)
    begin
      case (full_addr)
        `SPD_OFF_A_ADVANCE: next_rdata = synth_a_phase_advance;
        `SPD_OFF_B_ADVANCE: next_rdata = synth_b_phase_advance;
        `SPD_OFF_BANK: next_rdata = {7'h00, bank_sel};
        `SPD_OFF_DIV_LO: next_rdata = synth_a_first_output_divider[7:0];
        `SPD_OFF_DIV_MID: next_rdata = synth_a_first_output_divider[15:8];
        `SPD_OFF_DIV_HI: next_rdata = synth_a_first_output_divider[23:16];
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Register storage
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      synth_a_phase_advance <= `SPD_RST_ADVANCE;
      synth_b_phase_advance <= `SPD_RST_ADVANCE;
      bank_sel <= 1'b0;
      synth_a_first_output_divider <= `SPD_RST_DIV;
      HOST_RDATA <= 8'h00;
    end
    else
    begin
      synth_a_phase_advance <= next_a_adv;
      synth_b_phase_advance <= next_b_adv;
      bank_sel <= next_bank;
      synth_a_first_output_divider <= next_div;
      HOST_RDATA <= next_rdata;
    end
  end

  // Phase steps go straight to the synthesizer delay lines
  assign SYNTH_A_ADVANCE_STEPS = synth_a_phase_advance;
  assign SYNTH_B_ADVANCE_STEPS = synth_b_phase_advance;

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic special_mode;
  spd_src_e src_sel;
  logic edge_boundary;
  logic neg_polarity;
  logic [COUNT_WIDTH-1:0] count_field;

  assign special_mode = (synth_a_first_output_divider[`SPD_MODE_HI:`SPD_MODE_LO]
                         == `SPD_MODE_SPECIAL);
  assign src_sel = spd_src_e'(synth_a_first_output_divider[`SPD_SRC_HI:`SPD_SRC_LO]);
  assign edge_boundary = synth_a_first_output_divider[`SPD_BIT_BOUNDARY];
  assign neg_polarity = synth_a_first_output_divider[`SPD_BIT_POLARITY];
  assign count_field = synth_a_first_output_divider[`SPD_COUNT_HI:0];

  // ------------------------------------------------------------
  // Dividers
  // ------------------------------------------------------------
  logic plain_clk;
  logic low_clk;

  // Full 24-bit ratio on every synthesizer 0 cycle
  spd_divider #(.WIDTH(DIV_WIDTH)) u_plain_div
  (
    .clk(CLOCK),
    .rst_n(rst_n),
    .tick(1'b1),
    .divisor(synth_a_first_output_divider),
    .clk_out(plain_clk)
  );

  // BASE_TICK runs at twice the base rate, hence 2 x base / count
  spd_divider #(.WIDTH(COUNT_WIDTH)) u_low_div
  (
    .clk(CLOCK),
    .rst_n(rst_n),
    .tick(BASE_TICK),
    .divisor(count_field),
    .clk_out(low_clk)
  );

  // ------------------------------------------------------------
  // Frame pulse generator
  // ------------------------------------------------------------
  logic ref_clk;
  logic ref_prev;
  logic ref_rise;
  logic ref_fall;
  logic next_first_out;
  spd_frame_e fr_state;
  spd_frame_e next_fr_state;
  logic [COUNT_WIDTH-1:0] gap_cnt;
  logic [COUNT_WIDTH-1:0] next_gap_cnt;
  logic next_mark;
  logic frame_on;

  // Source select of the frame reference
  always_comb
  begin
    case (src_sel)
      SPD_SRC_LOWFREQ: ref_clk = low_clk;
      SPD_SRC_POST_B: ref_clk = POSTDIV_B_CLK;
      SPD_SRC_POST_C: ref_clk = POSTDIV_C_CLK;
      SPD_SRC_POST_D: ref_clk = POSTDIV_D_CLK;
      default: ref_clk = low_clk;
    endcase
  end

  // Inputs are synchronous, so one stage of history is enough for edges
  assign ref_rise = ref_clk & ~ref_prev;
  assign ref_fall = ~ref_clk & ref_prev;

  // Pulse starts on a rising edge that finds the count at zero, ends one period later
  always_comb
  begin
    next_fr_state = fr_state;
    next_gap_cnt = gap_cnt;
    next_mark = 1'b0;
    frame_on = special_mode && (src_sel != SPD_SRC_LOWFREQ);
    if (!frame_on)
    begin
      // Other modes park the generator so a later switch starts clean
      next_fr_state = SPD_FR_GAP;
      next_gap_cnt = '0;
    end
    else
    begin
      case (fr_state)
        SPD_FR_GAP:
        begin
          if (ref_rise && gap_cnt == '0)
          begin
            next_fr_state = SPD_FR_PULSE;
            next_mark = edge_boundary;
          end
        end
        SPD_FR_PULSE:
        begin
          if (ref_rise)
            next_fr_state = SPD_FR_GAP;
          else if (ref_fall && !edge_boundary)
            next_mark = 1'b1;
        end
        default: next_fr_state = SPD_FR_GAP;
      endcase
      if (ref_rise)
      begin
        // Count zero behaves as one: a pulse on every period
        if (gap_cnt >= count_field - COUNT_WIDTH'(1) || count_field == '0)
          next_gap_cnt = '0;
        else
          next_gap_cnt = gap_cnt + COUNT_WIDTH'(1);
      end
      // A back-to-back pulse when spacing is one period
      if (fr_state == SPD_FR_PULSE && ref_rise && next_gap_cnt == '0 && gap_cnt == '0)
      begin
        next_fr_state = SPD_FR_PULSE;
        next_mark = edge_boundary;
      end
    end
  end

  // Output select, registered so mode changes cannot glitch the pin
  always_comb
  begin
    if (!special_mode)
      next_first_out = plain_clk;
    else if (src_sel == SPD_SRC_LOWFREQ)
      next_first_out = low_clk;
    else
      next_first_out = (next_fr_state == SPD_FR_PULSE) ^ neg_polarity;
  end

  // Frame state, reference history and output pin registers
  always_ff @(posedge CLOCK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fr_state <= SPD_FR_GAP;
      gap_cnt <= '0;
      ref_prev <= 1'b0;
      FRAME_MARK <= 1'b0;
      FIRST_OUT <= 1'b0;
    end
    else
    begin
      fr_state <= next_fr_state;
      gap_cnt <= next_gap_cnt;
      ref_prev <= ref_clk;
      FRAME_MARK <= next_mark;
      FIRST_OUT <= next_first_out;
    end
  end

endmodule

`default_nettype wire

// File: tb/spd_asserts.sv
// Port checker for the synth config block
`timescale 1ns/1ps
`default_nettype none
module spd_asserts
#(
  parameter int DIV_WIDTH = 24,
  parameter int COUNT_WIDTH = 16
)
(
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [6:0] HOST_ADDR,
  input wire logic HOST_WR,
  input wire logic HOST_RD,
  input wire logic [7:0] HOST_WDATA,
  input wire logic [7:0] HOST_RDATA,
  input wire logic BASE_TICK,
  input wire logic POSTDIV_B_CLK,
  input wire logic POSTDIV_C_CLK,
  input wire logic POSTDIV_D_CLK,
  input wire logic [7:0] SYNTH_A_ADVANCE_STEPS,
  input wire logic [7:0] SYNTH_B_ADVANCE_STEPS,
  input wire logic FIRST_OUT,
  input wire logic FRAME_MARK
);
  // ----------
  // Shadow
  // ----------
  logic bank;
  logic next_bank;
  logic [DIV_WIDTH-1:0] div;
  logic [DIV_WIDTH-1:0] next_div;
  logic [7:0] div_byte;
  logic frame;
  logic adv_wr;

  // Bank bit and divisor follow host writes; byte 3 never read
  always_comb
  begin
    next_bank = bank;
    next_div = div;
    div_byte = div[HOST_ADDR[1:0]*8 +: 8];
    frame = div[23:20] == 4'hF && div[17:16] != 2'b00;
    adv_wr = HOST_WR && !bank && HOST_ADDR[6:1] == 6'h3C;
    if (HOST_WR && HOST_ADDR == 7'h7F)
      next_bank = HOST_WDATA[0];
    if (HOST_WR && bank && HOST_ADDR < 7'h03)
      next_div[HOST_ADDR[1:0]*8 +: 8] = HOST_WDATA;
  end

  // Shadow registers, cleared with the block
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      bank <= 1'b0;
      div <= 24'h00_0002;
    end
    else
    begin
      bank <= next_bank;
      div <= next_div;
    end
  end

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESETN);

  chk_adv_a_write:
    assert property (adv_wr && !HOST_ADDR[0] |=> SYNTH_A_ADVANCE_STEPS == $past(HOST_WDATA))
      else $error("advance A wrong");
  chk_adv_b_write:
    assert property (adv_wr && HOST_ADDR[0] |=> SYNTH_B_ADVANCE_STEPS == $past(HOST_WDATA))
      else $error("advance B wrong");
  chk_adv_steady:
    assert property (!adv_wr |=> $stable(SYNTH_A_ADVANCE_STEPS) && $stable(SYNTH_B_ADVANCE_STEPS))
      else $error("advance moved");
  chk_bank_read:
    assert property (HOST_RD && !HOST_WR && HOST_ADDR == 7'h7F |=> HOST_RDATA == {7'h00, bank})
      else $error("bank read wrong");
  chk_div_read:
    assert property (HOST_RD && !HOST_WR && bank && HOST_ADDR < 7'h03
      |=> HOST_RDATA == $past(div_byte)) else $error("divisor read wrong");
  chk_upper_empty:
    assert property (HOST_RD && bank && HOST_ADDR > 7'h02 && HOST_ADDR != 7'h7F
      |=> HOST_RDATA == 8'h00) else $error("unmapped read not zero");
  chk_rdata_held:
    assert property (!HOST_RD |=> $stable(HOST_RDATA)) else $error("read data moved");
  chk_plain_toggle:
    assert property ((div == 24'h00_0002) [*8] |-> FIRST_OUT != $past(FIRST_OUT))
      else $error("divide by two not toggling");
  chk_mark_mode:
    assert property (FRAME_MARK |-> frame || $past(frame) || $past(frame, 2))
      else $error("mark outside frame mode");

  // Main scenarios reached
  cov_mark: cover property (FRAME_MARK);
  cov_bank_read: cover property (HOST_RD && HOST_ADDR == 7'h7F);
  cov_low_freq: cover property (div[23:16] == 8'hF0 && $rose(FIRST_OUT));
endmodule
`default_nettype wire

// File: tb/synth_phase_and_postdivider_cfg_tb_top.sv
// Self-checking bench for the synth config block
`timescale 1ns/1ps
`default_nettype none
module synth_phase_and_postdivider_cfg_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] addr = 7'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic tick = 1'b0;
  logic ref_b = 1'b0;
  logic ref_c = 1'b0;
  logic ref_d = 1'b0;
  logic [7:0] rdata;
  logic [7:0] adv_a;
  logic [7:0] adv_b;
  logic first_out;
  logic mark;
  logic [7:0] got;
  int cyc = 0;
  int bad_count = 0;
  int num_checks = 0;
  int rises;
  int highs;
  int marks;
  int hits;
  int p;

  spd_top DUT
  (
    .CLOCK(clock), .RESETN(resetn), .HOST_ADDR(addr), .HOST_WR(wr), .HOST_RD(rd),
    .HOST_WDATA(wdata), .HOST_RDATA(rdata), .BASE_TICK(tick), .POSTDIV_B_CLK(ref_b),
    .POSTDIV_C_CLK(ref_c), .POSTDIV_D_CLK(ref_d), .SYNTH_A_ADVANCE_STEPS(adv_a),
    .SYNTH_B_ADVANCE_STEPS(adv_b), .FIRST_OUT(first_out), .FRAME_MARK(mark)
  );

  // 8 ns clock
  always #4 clock = ~clock;

  // Tick every 2 cycles; reference periods 6, 8 and 10 cycles
  always @(negedge clock)
  begin
    cyc++;
    tick = (cyc % 2 == 0);
    ref_b = (cyc % 6) < 3;
    ref_c = (cyc % 8) < 4;
    ref_d = (cyc % 10) < 5;
  end

  // ----------
  // Host tasks
  // ----------
  // Strobe stands one cycle; idle cycle between calls
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clock);
    wr = 1'b0;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t byte %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_count(input int g, input int e);
    num_checks++;
    if (g != e)
    begin
      bad_count++;
      $display("[ERR] %0t count %0d exp %0d", $time, g, e);
    end
  endtask

  // Read data lands on the edge that takes the strobe
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    @(negedge clock);
    addr = a;
    rd = 1'b1;
    @(negedge clock);
    rd = 1'b0;
    chk_byte(rdata, e);
  endtask

  // Leaves the bank bit at 1
  task automatic set_div(input logic [23:0] v);
    wr_reg(7'h7F, 8'h01);
    wr_reg(7'h00, v[7:0]);
    wr_reg(7'h01, v[15:8]);
    wr_reg(7'h02, v[23:16]);
  endtask

  // Window must span whole output periods for exact counts
  task automatic measure(input int n, input logic act);
    logic h1;
    logic h2;
    rises = 0;
    highs = 0;
    marks = 0;
    hits = 0;
    h1 = first_out;
    h2 = first_out;
    repeat (n)
    begin
      @(negedge clock);
      rises += (first_out === 1'b1 && h1 === 1'b0);
      highs += (first_out === 1'b1);
      marks += (mark === 1'b1);
      hits += (mark === 1'b1 && h2 === act);
      h2 = h1;
      h1 = first_out;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    chk_byte(adv_a, 8'h00);
    chk_byte(adv_b, 8'h00);
    rd_chk(7'h7F, 8'h00);
    wr_reg(7'h78, 8'hA5);
    wr_reg(7'h79, 8'hFF);
    chk_byte(adv_a, 8'hA5);
    chk_byte(adv_b, 8'hFF);
    rd_chk(7'h79, 8'hFF);
    wr_reg(7'h7F, 8'hFF);
    rd_chk(7'h7F, 8'h01);
    rd_chk(7'h00, 8'h02);
    rd_chk(7'h02, 8'h00);
    wr_reg(7'h78, 8'h3C);
    rd_chk(7'h78, 8'h00);
    wr_reg(7'h7F, 8'h00);
    rd_chk(7'h78, 8'hA5);
    // Plain divide: high for ceil(N/2) of N cycles
    for (int d = 3; d < 6; d++)
    begin
      set_div(24'(d));
      repeat (8) @(negedge clock);
      measure(60, 1'b0);
      chk_count(rises, 60 / d);
      chk_count(highs, (60 / d) * ((d + 1) / 2));
    end
    // Low-frequency clock: 4 ticks of 2 cycles
    set_div(24'hF0_0004);
    rd_chk(7'h02, 8'hF0);
    repeat (30) @(negedge clock);
    measure(64, 1'b0);
    chk_count(rises, 8);
    chk_count(highs, 32);
    // Frame pulses every 3 periods of source s, bit 19 and bit 18 swept
    for (int s = 1; s < 4; s++)
    begin
      for (int m = 0; m < 4; m++)
      begin
        p = 4 + 2 * s;
        set_div({4'hF, m[1], m[0], s[1:0], 16'h0003});
        repeat (9 * p) @(negedge clock);
        measure(12 * p, ~m[0]);
        chk_count(marks, 4);
        chk_count(highs, m[0] ? 8 * p : 4 * p);
        chk_count(hits, m[1] ? 0 : 4);
      end
    end
    wrap_up();
  end
endmodule

bind spd_top spd_asserts #(.DIV_WIDTH(DIV_WIDTH), .COUNT_WIDTH(COUNT_WIDTH)) u_chk
(
  .CLOCK, .RESETN, .HOST_ADDR, .HOST_WR, .HOST_RD, .HOST_WDATA, .HOST_RDATA, .BASE_TICK,
  .POSTDIV_B_CLK, .POSTDIV_C_CLK, .POSTDIV_D_CLK, .SYNTH_A_ADVANCE_STEPS,
  .SYNTH_B_ADVANCE_STEPS, .FIRST_OUT, .FRAME_MARK
);
`default_nettype wire
